// file: test/tb_rsa_alu.sv
// Self-checking bench for the rotate, subtract and swap datapath
`timescale 1ns/1ns
module tb_rsa_alu;
  //****
  // Signals and model state
  //****
  localparam int PS = 4;
  logic core_clk, arst_n, psel, penable, pwrite, wdt_tick, pready, pslverr, freg_we;
  logic [7:0] paddr, freg_wdata, acc, res, r;
  logic [31:0] pwdata, prdata, s, x;
  logic [6:0] freg_addr;
  logic c, hb, z, pdn, tout;
  logic [33:0] e;
  logic [33:0] aq[$];
  logic [14:0] fq[$];
  int n_fail, compares, tk;
  // Prescaler of 4 ticks keeps the watchdog counts short
  rsa_alu #(.PRESCALE_W(2)) dut_u (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wdt_tick(wdt_tick), .freg_addr(freg_addr),
    .freg_wdata(freg_wdata), .freg_we(freg_we));
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  //****
  // Drivers
  //****
  // One APB transfer, then an idle cycle so psel never toggles twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic er);
    int n;
    aq.push_back({~wr, er, d});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      n_fail++;
      print_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic tick(input int n);
    wdt_tick <= 1'b1;
    repeat (n) @(posedge core_clk);
    wdt_tick <= 1'b0;
    tk += n;
    @(posedge core_clk);
    apb(1'b0, rsa_pkg::OFS_WDT, 32'(tk / PS), 1'b0);
  endtask
  task automatic run_op(input logic [3:0] o, input logic dst, input logic [7:0] f, input logic [6:0] fa);
    r = res;
    case (o)
      rsa_pkg::ROTATE_RIGHT_THROUGH_CARRY_OP:
      begin
        r = {c, f[7:1]};
        c = f[0];
      end
      rsa_pkg::REGISTER_MINUS_ACC_OP, rsa_pkg::LITERAL_MINUS_ACC_OP:
      begin
        r = f - acc;
        c = acc <= f;
        hb = acc[3:0] <= f[3:0];
        z = r == 8'h00;
      end
      rsa_pkg::SUBTRACT_WITH_BORROW_OP:
      begin
        r = f - acc - {7'h00, ~c};
        hb = {1'b0, acc[3:0]} + {4'h0, ~c} <= {1'b0, f[3:0]};
        c = {1'b0, acc} + {8'h00, ~c} <= {1'b0, f};
        z = r == 8'h00;
      end
      rsa_pkg::NIBBLE_EXCHANGE_OP: r = {f[3:0], f[7:4]};
      rsa_pkg::LOW_POWER_ENTRY_OP:
      begin
        pdn = 1'b0;
        tout = 1'b1;
        tk = 0;
      end
      default: r = res;
    endcase
    if (o inside {[4'h1:4'h5]})
    begin
      res = r;
      // Literal subtract ignores the destination bit
      if (dst && o != rsa_pkg::LITERAL_MINUS_ACC_OP)
        fq.push_back({fa, r});
      else
        acc = r;
    end
    apb(1'b1, rsa_pkg::OFS_CMD, {9'h000, fa, f, 3'h0, dst, o}, 1'b0);
    apb(1'b0, rsa_pkg::OFS_ACC, {24'h0, acc}, 1'b0);
    apb(1'b0, rsa_pkg::OFS_STATUS, {27'h0, tout, pdn, z, hb, c}, 1'b0);
    apb(1'b0, rsa_pkg::OFS_RESULT, {24'h0, res}, 1'b0);
  endtask
  // Monitor pairs each completed access and write-back with the oldest note
  always @(posedge core_clk)
  begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
    begin
      e = aq.pop_front();
      chk("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
      if (e[33])
        chk("prdata", prdata, e[31:0]);
    end
    if (freg_we !== 1'b0)
    begin
      chk("freg_we", {31'h0, freg_we}, {31'h0, fq.size() != 0});
      if (fq.size() != 0)
        chk("freg", {17'h0, freg_addr, freg_wdata}, {17'h0, fq.pop_front()});
    end
  end
  initial
  begin
    {arst_n, psel, penable, pwrite, wdt_tick, paddr, pwdata} = '0;
    {acc, res, c, hb, z, pdn, tout, tk} = {16'h0, 3'h0, 2'h3, 32'h0};
    s = 32'h00004131;
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    run_op(4'h7, 1'b0, 8'h5A, 7'h01);
    run_op(4'h0, 1'b1, 8'hA5, 7'h02);
    tick(10);
    run_op(rsa_pkg::LOW_POWER_ENTRY_OP, 1'b0, 8'h00, 7'h00);
    tick(3);
    tick(1);
    apb(1'b1, 8'h14, 32'hFF, 1'b1);
    apb(1'b0, 8'h14, 32'h0, 1'b1);
    repeat (80)
    begin
      x = rnd();
      apb(1'b1, rsa_pkg::OFS_ACC, {24'h0, x[7:0]}, 1'b0);
      acc = x[7:0];
      run_op(4'(1 + x[31:24] % 6), x[17], x[16] ? x[7:0] : x[15:8], x[30:24]);
    end
    chk("pending", 32'(fq.size()), 32'h0);
    print_verdict();
  end
endmodule

// file: verilog/rsa_alu.sv
// Rotate, subtract and swap datapath with APB command port
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
module rsa_alu #(
  parameter int PRESCALE_W = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Watchdog tick from the clock tree
  input wire logic wdt_tick,
  // File register write-back
  output logic [6:0] freg_addr,
  output logic [7:0] freg_wdata,
  output logic freg_we
);
  //**********************************************************************
  // Bus decode
  //**********************************************************************
  // Prescaler wider than 16 bits would never wrap in practice
  if (PRESCALE_W < 1 || PRESCALE_W > 16)
  begin : g_prescale_range
    $error("PRESCALE_W out of range");
  end

  logic [7:0] acc_ff;
  logic [4:0] status_ff;
  logic [7:0] result_ff;
  logic [7:0] watchdog_counter_ff;
  logic [PRESCALE_W-1:0] wdt_pre_ff;
  logic [6:0] fadr_ff;
  logic fwe_ff;

  // Single-cycle answer keeps the slave simple
  wire logic acc_phase = psel && penable;
  wire logic wr_cmd = acc_phase && pwrite && (paddr == rsa_pkg::OFS_CMD);
  wire logic wr_acc = acc_phase && pwrite && (paddr == rsa_pkg::OFS_ACC);
  wire logic hit = (paddr == rsa_pkg::OFS_CMD) || (paddr == rsa_pkg::OFS_ACC)
    || (paddr == rsa_pkg::OFS_STATUS) || (paddr == rsa_pkg::OFS_RESULT)
    || (paddr == rsa_pkg::OFS_WDT);
  assign pready = 1'b1;
  assign pslverr = acc_phase && !hit;

  // Read mux
  always_comb
  begin
    if (paddr == rsa_pkg::OFS_ACC)
      prdata = {24'h000000, acc_ff};
    else if (paddr == rsa_pkg::OFS_STATUS)
      prdata = {27'h0000000, status_ff};
    else if (paddr == rsa_pkg::OFS_RESULT)
      prdata = {24'h000000, result_ff};
    else if (paddr == rsa_pkg::OFS_WDT)
      prdata = {24'h000000, watchdog_counter_ff};
    else
      prdata = 32'h00000000;
  end

  //**********************************************************************
  // Datapath
  //**********************************************************************
  wire logic [3:0] opc = pwdata[rsa_pkg::CMD_OPC_LSB +: 4];
  wire logic dest = pwdata[rsa_pkg::CMD_DEST_BIT];
  wire logic [7:0] opd = pwdata[rsa_pkg::CMD_OPD_LSB +: 8];
  wire logic [6:0] fadr = pwdata[rsa_pkg::CMD_FADR_LSB +: 7];
  wire logic c_in = status_ff[rsa_pkg::ST_C];
  // Borrow is the inverted carry; only the borrowing subtract uses it
  // inverted carry borrow
  wire logic bin = (opc == rsa_pkg::SUBTRACT_WITH_BORROW_OP) ? !c_in : 1'b0;
  // Subtract as add of complement: carry out high means no borrow
  wire logic [8:0] diff = {1'b0, opd} + {1'b0, ~acc_ff} + {8'h00, !bin};
  wire logic [4:0] ldiff = {1'b0, opd[3:0]} + {1'b0, ~acc_ff[3:0]} + {4'h0, !bin};
  wire logic is_sub = (opc == rsa_pkg::REGISTER_MINUS_ACC_OP)
    || (opc == rsa_pkg::LITERAL_MINUS_ACC_OP) || (opc == rsa_pkg::SUBTRACT_WITH_BORROW_OP);
  wire logic is_rot = (opc == rsa_pkg::ROTATE_RIGHT_THROUGH_CARRY_OP);
  wire logic is_swp = (opc == rsa_pkg::NIBBLE_EXCHANGE_OP);
  wire logic is_lpe = (opc == rsa_pkg::LOW_POWER_ENTRY_OP);
  wire logic has_dest = is_rot || is_swp || (is_sub && opc != rsa_pkg::LITERAL_MINUS_ACC_OP);
  // Operations that produce a result word
  wire logic is_alu = is_rot || is_swp || is_sub;

  logic [7:0] res;
  // Result select
  always_comb
  begin
    if (is_rot)
      res = {c_in, opd[7:1]};
    else if (is_swp)
      res = {opd[3:0], opd[7:4]};
    else if (is_sub)
      res = diff[7:0];
    else
      res = 8'h00;
  end

  logic [4:0] nxt_status;
  // Flag update
  always_comb
  begin
    nxt_status = status_ff;
    if (wr_cmd && is_rot)
      nxt_status[rsa_pkg::ST_C] = opd[0];
    if (wr_cmd && is_sub)
    begin
      nxt_status[rsa_pkg::ST_C] = diff[8];
      nxt_status[rsa_pkg::ST_DC] = ldiff[4];
      nxt_status[rsa_pkg::ST_Z] = (diff[7:0] == 8'h00);
    end
    if (wr_cmd && is_lpe)
    begin
      nxt_status[rsa_pkg::ST_PD] = 1'b0;
      nxt_status[rsa_pkg::ST_TO] = 1'b1;
    end
  end

  wire logic to_freg = wr_cmd && has_dest && dest;
  wire logic to_acc = (wr_cmd && is_alu && !to_freg) || wr_acc;
  wire logic [7:0] nxt_acc = wr_acc ? pwdata[7:0] : res;

  // State registers
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acc_ff <= rsa_pkg::ACC_RST;
      status_ff <= rsa_pkg::STATUS_RST;
      result_ff <= 8'h00;
      fadr_ff <= 7'h00;
      fwe_ff <= 1'b0;
    end
    else
    begin
      if (to_acc)
        acc_ff <= nxt_acc;
      status_ff <= nxt_status;
      // Low-power entry and unknown codes leave the result alone
      if (wr_cmd && is_alu)
        result_ff <= res;
      fwe_ff <= to_freg;
      if (to_freg)
        fadr_ff <= fadr;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      watchdog_counter_ff <= rsa_pkg::WDT_ZERO;
      wdt_pre_ff <= '0;
    end
    else if (wr_cmd && is_lpe)
    begin
      watchdog_counter_ff <= rsa_pkg::WDT_ZERO;
      wdt_pre_ff <= '0;
    end
    else if (wdt_tick)
    begin
      wdt_pre_ff <= wdt_pre_ff + PRESCALE_W'(1);
      if (&wdt_pre_ff)
        watchdog_counter_ff <= watchdog_counter_ff + 8'h01;
    end
  end

  assign freg_addr = fadr_ff;
  assign freg_wdata = result_ff;
  assign freg_we = fwe_ff;

  //**********************************************************************
  // Assertions
  //**********************************************************************
  property p_rot;
    @(posedge core_clk) disable iff (!arst_n)
    (wr_cmd && is_rot) |=> (result_ff == {$past(c_in), $past(opd[7:1])})
      && (status_ff[rsa_pkg::ST_C] == $past(opd[0]));
  endproperty
  a_rot: assert property (p_rot) else $error("rotate wrong");

  property p_dest;
    @(posedge core_clk) disable iff (!arst_n)
    (wr_cmd && has_dest) |=> (freg_we == $past(dest)) && (freg_we || acc_ff == result_ff);
  endproperty
  a_dest: assert property (p_dest) else $error("destination wrong");

  property p_wdt;
    @(posedge core_clk) disable iff (!arst_n)
    (wr_cmd && is_lpe) |=> (watchdog_counter_ff == 8'h00) && (wdt_pre_ff == '0);
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog not cleared");

  property p_lpe;
    @(posedge core_clk) disable iff (!arst_n)
    (wr_cmd && is_lpe) |=> !status_ff[rsa_pkg::ST_PD] && status_ff[rsa_pkg::ST_TO]
      && (status_ff[2:0] == $past(status_ff[2:0]));
  endproperty
  a_lpe: assert property (p_lpe) else $error("low power flags wrong");

  property p_sub;
    @(posedge core_clk) disable iff (!arst_n)
    (wr_cmd && opc == rsa_pkg::REGISTER_MINUS_ACC_OP) |=>
      (result_ff == 8'($past(opd) - $past(acc_ff)))
      && (status_ff[rsa_pkg::ST_C] == ($past(acc_ff) <= $past(opd)));
  endproperty
  a_sub: assert property (p_sub) else $error("register subtract wrong");

  property p_lit;
    @(posedge core_clk) disable iff (!arst_n)
    (wr_cmd && opc == rsa_pkg::LITERAL_MINUS_ACC_OP) |=> !freg_we
      && (acc_ff == result_ff) && (status_ff[rsa_pkg::ST_DC] == ($past(acc_ff[3:0])
      <= $past(opd[3:0]))) && (status_ff[rsa_pkg::ST_Z] == (result_ff == 8'h00));
  endproperty
  a_lit: assert property (p_lit) else $error("literal subtract wrong");

  property p_swb;
    @(posedge core_clk) disable iff (!arst_n)
    (wr_cmd && opc == rsa_pkg::SUBTRACT_WITH_BORROW_OP) |=>
      (result_ff == 8'($past(opd) - $past(acc_ff) - {7'h00, !$past(c_in)}));
  endproperty
  a_swb: assert property (p_swb) else $error("borrow subtract wrong");

  property p_swp;
    @(posedge core_clk) disable iff (!arst_n)
    (wr_cmd && is_swp) |=> (status_ff == $past(status_ff))
      && (result_ff == {$past(opd[3:0]), $past(opd[7:4])});
  endproperty
  a_swp: assert property (p_swp) else $error("swap wrong");

  // Flags and destinations that the checks above leave open
  property p_rot_keep;
    @(posedge core_clk) disable iff (!arst_n)
    (wr_cmd && is_rot) |=> (status_ff[rsa_pkg::ST_TO:rsa_pkg::ST_DC]
      == $past(status_ff[rsa_pkg::ST_TO:rsa_pkg::ST_DC]));
  endproperty
  a_rot_keep: assert property (p_rot_keep) else $error("rotate touched flags");

  property p_rot_acc;
    @(posedge core_clk) disable iff (!arst_n)
    (wr_cmd && is_rot && !dest) |=> (acc_ff == {$past(c_in), $past(opd[7:1])});
  endproperty
  a_rot_acc: assert property (p_rot_acc) else $error("rotate accumulator wrong");

  property p_dest_acc;
    @(posedge core_clk) disable iff (!arst_n)
    (wr_cmd && has_dest && dest) |=> (acc_ff == $past(acc_ff));
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("accumulator changed");

  property p_freg_addr;
    @(posedge core_clk) disable iff (!arst_n)
    (wr_cmd && has_dest && dest) |=> (freg_addr == $past(fadr));
  endproperty
  a_freg_addr: assert property (p_freg_addr) else $error("write-back address wrong");

  property p_freg_pulse;
    @(posedge core_clk) disable iff (!arst_n)
    freg_we |=> !freg_we;
  endproperty
  a_freg_pulse: assert property (p_freg_pulse) else $error("write-back pulse too long");

  property p_lpe_keep;
    @(posedge core_clk) disable iff (!arst_n)
    (wr_cmd && is_lpe) |=> (acc_ff == $past(acc_ff)) && (result_ff == $past(result_ff))
      && !freg_we;
  endproperty
  a_lpe_keep: assert property (p_lpe_keep) else $error("low power touched data");

  property p_sub_flags;
    @(posedge core_clk) disable iff (!arst_n)
    (wr_cmd && opc == rsa_pkg::REGISTER_MINUS_ACC_OP) |=>
      (status_ff[rsa_pkg::ST_DC] == ($past(acc_ff[3:0]) <= $past(opd[3:0])))
      && (status_ff[rsa_pkg::ST_Z] == (result_ff == 8'h00));
  endproperty
  a_sub_flags: assert property (p_sub_flags) else $error("register subtract flags wrong");

  property p_lit_val;
    @(posedge core_clk) disable iff (!arst_n)
    (wr_cmd && opc == rsa_pkg::LITERAL_MINUS_ACC_OP) |=>
      (result_ff == 8'($past(opd) - $past(acc_ff)))
      && (status_ff[rsa_pkg::ST_C] == ($past(acc_ff) <= $past(opd)));
  endproperty
  a_lit_val: assert property (p_lit_val) else $error("literal subtract value wrong");

  property p_swb_flags;
    @(posedge core_clk) disable iff (!arst_n)
    (wr_cmd && opc == rsa_pkg::SUBTRACT_WITH_BORROW_OP) |=>
      (status_ff[rsa_pkg::ST_C] == ({1'b0, $past(acc_ff)} + {8'h00, !$past(c_in)}
      <= {1'b0, $past(opd)}))
      && (status_ff[rsa_pkg::ST_DC] == ({1'b0, $past(acc_ff[3:0])}
      + {4'h0, !$past(c_in)} <= {1'b0, $past(opd[3:0])}))
      && (status_ff[rsa_pkg::ST_Z] == (result_ff == 8'h00));
  endproperty
  a_swb_flags: assert property (p_swb_flags) else $error("borrow subtract flags wrong");

  property p_swp_acc;
    @(posedge core_clk) disable iff (!arst_n)
    (wr_cmd && is_swp && !dest) |=> (acc_ff == {$past(opd[3:0]), $past(opd[7:4])});
  endproperty
  a_swp_acc: assert property (p_swp_acc) else $error("swap accumulator wrong");
endmodule

// file: verilog/rsa_pkg.sv
// Constants for the rotate, subtract and swap datapath
//**********************************************************************
// Functional notes
// - Rotate right moves the register right through carry, old carry into bit 7, bit 0 to carry.
// - Destination bit 0 sends the result to the accumulator, 1 back to the file register; literal subtract always writes the accumulator.
// - Low-power entry loads the watchdog counter and its prescaler with zero.
// - Low-power entry clears the power-down flag, sets the timeout flag, touches no other flag.
// - Register subtract gives register minus accumulator with carry, half carry and zero.
// - Literal subtract gives literal minus accumulator into the accumulator with flags.
// - Subtract with borrow also takes away the inverted carry and updates three flags.
//**********************************************************************
package rsa_pkg;
  // APB register offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ACC = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0C;
  localparam logic [7:0] OFS_WDT = 8'h10;
  // Command register fields
  localparam int CMD_OPC_LSB = 0;
  localparam int CMD_DEST_BIT = 4;
  localparam int CMD_OPD_LSB = 8;
  localparam int CMD_FADR_LSB = 16;
  // Status register bit positions
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  // Reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [4:0] STATUS_RST = 5'h18;
  localparam logic [7:0] WDT_ZERO = 8'h00;
  // Operations
  typedef enum logic [3:0] {
    RSA_NOP = 4'h0,
    ROTATE_RIGHT_THROUGH_CARRY_OP = 4'h1,
    REGISTER_MINUS_ACC_OP = 4'h2,
    LITERAL_MINUS_ACC_OP = 4'h3,
    SUBTRACT_WITH_BORROW_OP = 4'h4,
    NIBBLE_EXCHANGE_OP = 4'h5,
    LOW_POWER_ENTRY_OP = 4'h6
  } rsa_op_e;
endpackage
